// [rtl/aux_timer_chain.sv]
/*
  Core timer with two auxiliary timers: counting, concatenation through the
  overflow toggle latch, reload of the core timer and capture of the core timer.
  Assumes external pins held stable at least four clocks between changes and a
  register master that drives one strobe per cycle.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - counter mode edge field picks own pin edges or toggle latch edges; X00 stops.
// - edge code 111 counts on both toggle latch transitions.
// - only overflow-driven latch changes clock auxiliary counters, never software writes.
// - both latch edges selected: auxiliary steps once per core overflow.
// - one latch edge selected: auxiliary steps every second overflow, 33 bits.
// - chained timers keep their own directions; core may time, gate or count.
// - mode 100 reloads core from auxiliary on the selected trigger edge.
// - in reload mode the auxiliary timer never counts, whatever its run bit.
// - each reload loads core and sets that auxiliary interrupt flag.
// - latch-triggered reload also sets the core interrupt flag.
// - software writes to the toggle latch never cause a reload.
// - rise-edge and fall-edge reload timers alternate, giving PWM high and low times.
// - latch drives core output line only while output enable is set.
// - both timers on same reload event: second timer's value loads core, both flags set.
// - mode 101 captures core timer into auxiliary on selected pin edge.
// - capture uses only the low two edge bits; the top bit is ignored.
// - each capture sets the capturing timer's interrupt flag.
// - remote run option lets core run bit start and stop the auxiliary timer.
module aux_timer_chain (
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  input  wire logic                        i_core_pin,
  input  wire logic                        i_aux_a_pin,
  input  wire logic                        i_aux_b_pin,
  input  wire logic [gpt_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [gpt_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [gpt_pkg::DATA_W-1:0]  o_rdata,
  output logic                             o_core_output_line,
  output logic      [gpt_pkg::IRQ_W-1:0]   o_irq_flags
);

  typedef struct packed {
    gpt_pkg::con_t                                  core;
    gpt_pkg::con_t [gpt_pkg::NUM_AUX-1:0]           aux;
    logic [15:0]                                    core_cnt;
    logic [gpt_pkg::NUM_AUX-1:0][15:0]              aux_cnt;
    logic                                           otl;
    logic [gpt_pkg::IRQ_W-1:0]                      irq;
    logic                                           out_line;
    logic [gpt_pkg::DATA_W-1:0]                     rdata;
  } state_t;

  state_t                           st;
  state_t                           next_st;
  logic [gpt_pkg::NUM_PINS-1:0]     pin_level;
  logic [gpt_pkg::NUM_PINS-1:0]     pin_rise;
  logic [gpt_pkg::NUM_PINS-1:0]     pin_fall;
  logic [gpt_pkg::PSC_W-1:0]        psc;
  logic                             core_evt;
  logic                             core_ovf;
  logic                             otl_rise;
  logic                             otl_fall;
  logic [gpt_pkg::NUM_AUX-1:0]      aux_run;
  logic [gpt_pkg::NUM_AUX-1:0]      aux_evt;
  logic [gpt_pkg::NUM_AUX-1:0]      reload_hit;
  logic [gpt_pkg::NUM_AUX-1:0]      cap_hit;
  logic [gpt_pkg::IRQ_W-1:0]        irq_set;
  logic [gpt_pkg::IRQ_W-1:0]        irq_clr;

  edge_sampler #(
    .N (gpt_pkg::NUM_PINS)
  ) u_pins (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pins   ({i_aux_b_pin, i_aux_a_pin, i_core_pin}),
    .o_level  (pin_level),
    .o_rise   (pin_rise),
    .o_fall   (pin_fall)
  );

  prescale_counter u_psc (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .o_count  (psc)
  );

  // prescaler tick: base rate divided by two to the power of the select field
  function automatic logic psc_tick(input logic [gpt_pkg::PSC_W-1:0] cnt, input logic [2:0] sel);
    logic [gpt_pkg::PSC_W-1:0] mask;
    mask = (gpt_pkg::PSC_W'(gpt_pkg::PSC_BASE) << sel) - gpt_pkg::PSC_W'(1);
    return (cnt & mask) == mask;
  endfunction

  // edge decode shared by counting, reload and capture
  function automatic logic edge_hit(input logic [2:0] sel, input logic rise, input logic fall,
                                    input logic orise, input logic ofall);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      gpt_pkg::EDGE_PIN_RISE: hit = rise;
      gpt_pkg::EDGE_PIN_FALL: hit = fall;
      gpt_pkg::EDGE_PIN_ANY:  hit = rise | fall;
      gpt_pkg::EDGE_OTL_RISE: hit = orise;
      gpt_pkg::EDGE_OTL_FALL: hit = ofall;
      gpt_pkg::EDGE_OTL_ANY:  hit = orise | ofall;
      default:                hit = 1'b0;
    endcase
    return hit;
  endfunction

  // count enable for timer, gated timer and counter modes
  function automatic logic count_hit(input gpt_pkg::con_t con, input logic tick, input logic level,
                                     input logic rise, input logic fall, input logic orise,
                                     input logic ofall);
    logic hit;
    hit = 1'b0;
    unique case (con.mode)
      gpt_pkg::MODE_TIMER:    hit = tick;
      gpt_pkg::MODE_COUNTER:  hit = edge_hit(con.sel, rise, fall, orise, ofall);
      gpt_pkg::MODE_GATED_HI: hit = tick & level;
      gpt_pkg::MODE_GATED_LO: hit = tick & ~level;
      default:                hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [15:0] step(input logic [15:0] v, input logic down);
    return down ? v - gpt_pkg::CNT_ONE : v + gpt_pkg::CNT_ONE;
  endfunction

  always_comb begin
    next_st    = st;
    irq_set    = '0;
    irq_clr    = '0;
    reload_hit = '0;
    cap_hit    = '0;
    aux_run    = '0;
    aux_evt    = '0;

    // core timer counts in its own direction
    core_evt = st.core.run &&
               count_hit(st.core, psc_tick(psc, st.core.sel), pin_level[0], pin_rise[0],
                         pin_fall[0], 1'b0, 1'b0);
    core_ovf = core_evt &&
               (st.core.down ? st.core_cnt == gpt_pkg::CNT_ZERO : st.core_cnt == gpt_pkg::CNT_MAX);
    if (core_evt) begin
      next_st.core_cnt = step(st.core_cnt, st.core.down);
    end
    // latch edges come only from hardware overflow
    otl_rise = core_ovf && !st.otl;
    otl_fall = core_ovf && st.otl;
    if (core_ovf) begin
      next_st.otl       = ~st.otl;
      irq_set[gpt_pkg::IRQ_CORE] = 1'b1;
    end

    // timer b is handled after timer a so its reload overrides
    for (int i = 0; i < gpt_pkg::NUM_AUX; i++) begin
      aux_run[i] = st.aux[i].remote ? st.core.run : st.aux[i].run;
      unique case (st.aux[i].mode)
        gpt_pkg::MODE_RELOAD: begin
          // no counting here, run bit ignored
          reload_hit[i] = edge_hit(st.aux[i].sel, pin_rise[i+1], pin_fall[i+1],
                                   otl_rise, otl_fall);
          if (reload_hit[i]) begin
            next_st.core_cnt = st.aux_cnt[i];
            irq_set[gpt_pkg::IRQ_AUXA+i] = 1'b1;
            if (st.aux[i].sel[2]) begin
              irq_set[gpt_pkg::IRQ_CORE] = 1'b1;
            end
          end
        end
        gpt_pkg::MODE_CAPTURE: begin
          cap_hit[i] = edge_hit({1'b0, st.aux[i].sel[1:0]}, pin_rise[i+1], pin_fall[i+1],
                                1'b0, 1'b0);
          if (cap_hit[i]) begin
            next_st.aux_cnt[i] = st.core_cnt;
            irq_set[gpt_pkg::IRQ_AUXA+i] = 1'b1;
          end
        end
        default: begin
          aux_evt[i] = aux_run[i] &&
                       count_hit(st.aux[i], psc_tick(psc, st.aux[i].sel), pin_level[i+1],
                                 pin_rise[i+1], pin_fall[i+1], otl_rise,
                                 otl_fall);
          if (aux_evt[i]) begin
            next_st.aux_cnt[i] = step(st.aux_cnt[i], st.aux[i].down);
          end
        end
      endcase
    end

    // software access; written counts override hardware updates
    if (i_wr) begin
      unique case (i_addr)
        gpt_pkg::REG_CORE_CON: begin
          next_st.core = gpt_pkg::con_t'(i_wdata[gpt_pkg::CON_W-1:0]);
          next_st.otl  = i_wdata[gpt_pkg::OTL_BIT];
        end
        gpt_pkg::REG_CORE_CNT: next_st.core_cnt   = i_wdata;
        gpt_pkg::REG_AUXA_CON: next_st.aux[0]     = gpt_pkg::con_t'(i_wdata[gpt_pkg::CON_W-1:0]);
        gpt_pkg::REG_AUXA_CNT: next_st.aux_cnt[0] = i_wdata;
        gpt_pkg::REG_AUXB_CON: next_st.aux[1]     = gpt_pkg::con_t'(i_wdata[gpt_pkg::CON_W-1:0]);
        gpt_pkg::REG_AUXB_CNT: next_st.aux_cnt[1] = i_wdata;
        gpt_pkg::REG_IRQ:      irq_clr            = i_wdata[gpt_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // a flag set in the clearing cycle survives
    next_st.irq = (st.irq & ~irq_clr) | irq_set;

    next_st.rdata = '0;
    if (i_rd) begin
      unique case (i_addr)
        gpt_pkg::REG_CORE_CON: begin
          next_st.rdata = gpt_pkg::DATA_W'(st.core) & ~(gpt_pkg::DATA_W'(1) << gpt_pkg::OTL_BIT);
          next_st.rdata[gpt_pkg::OTL_BIT] = st.otl;
        end
        gpt_pkg::REG_CORE_CNT: next_st.rdata = st.core_cnt;
        gpt_pkg::REG_AUXA_CON: next_st.rdata = gpt_pkg::DATA_W'({1'b0, st.aux[0][gpt_pkg::CON_W-2:0]});
        gpt_pkg::REG_AUXA_CNT: next_st.rdata = st.aux_cnt[0];
        gpt_pkg::REG_AUXB_CON: next_st.rdata = gpt_pkg::DATA_W'({1'b0, st.aux[1][gpt_pkg::CON_W-2:0]});
        gpt_pkg::REG_AUXB_CNT: next_st.rdata = st.aux_cnt[1];
        gpt_pkg::REG_IRQ:      next_st.rdata = gpt_pkg::DATA_W'(st.irq);
        default:               next_st.rdata = '0;
      endcase
    end

    next_st.out_line = next_st.otl & next_st.core.oe;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata            = st.rdata;
  assign o_core_output_line = st.out_line;
  assign o_irq_flags        = st.irq;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_quiet_ovf;
    core_ovf && !i_wr;
  endsequence

  sequence s_chain32(int k);
    st.aux[k].mode == gpt_pkg::MODE_COUNTER && st.aux[k].sel == gpt_pkg::EDGE_OTL_ANY && aux_run[k];
  endsequence

  sequence s_chain33_skip;
    st.aux[1].mode == gpt_pkg::MODE_COUNTER && st.aux[1].sel == gpt_pkg::EDGE_OTL_RISE && st.otl;
  endsequence

  sequence s_latch_write;
    i_wr && i_addr == gpt_pkg::REG_CORE_CON;
  endsequence

  sequence s_pwm_pair;
    st.aux[0].mode == gpt_pkg::MODE_RELOAD && st.aux[0].sel == gpt_pkg::EDGE_OTL_RISE &&
    st.aux[1].mode == gpt_pkg::MODE_RELOAD && st.aux[1].sel == gpt_pkg::EDGE_OTL_FALL;
  endsequence

  a_otl_toggle_ovf: assert property (
    s_quiet_ovf |=> st.otl != $past(st.otl) && st.irq[gpt_pkg::IRQ_CORE])
    else $error("toggle latch did not invert on overflow");

  a_sw_otl_quiet: assert property (
    s_latch_write ##1 (!core_ovf && !i_wr && st.aux[0].mode == gpt_pkg::MODE_COUNTER && st.aux[0].sel[2])
      |=> $stable(st.aux_cnt[0]))
    else $error("latch event without core overflow");

  a_chain_32bit: assert property (
    s_quiet_ovf and s_chain32(0) |=> st.aux_cnt[0] != $past(st.aux_cnt[0]))
    else $error("32-bit chain missed a step");

  a_chain_33bit: assert property (
    s_quiet_ovf and s_chain33_skip |=> st.aux_cnt[1] == $past(st.aux_cnt[1]))
    else $error("33-bit chain stepped on wrong latch edge");

  a_reload_no_count: assert property (
    st.aux[0].mode == gpt_pkg::MODE_RELOAD && !i_wr |=> $stable(st.aux_cnt[0]))
    else $error("timer counted in reload mode");

  a_reload_loads: assert property (
    reload_hit[0] && !reload_hit[1] && !i_wr |=> st.core_cnt == $past(st.aux_cnt[0]) && st.irq[gpt_pkg::IRQ_AUXA])
    else $error("reload did not load core or set flag");

  a_reload_core_irq: assert property (
    reload_hit[1] && st.aux[1].sel[2] |=> st.irq[gpt_pkg::IRQ_CORE] ##1 1'b1)
    else $error("latch reload did not set core flag");

  a_reload_prio: assert property (
    reload_hit == 2'h3 && !i_wr |=> st.core_cnt == $past(st.aux_cnt[1]))
    else $error("second timer did not win reload");

  a_capture_core: assert property (
    cap_hit[1] && !i_wr |=> st.aux_cnt[1] == $past(st.core_cnt) && st.irq[gpt_pkg::IRQ_AUXB])
    else $error("capture value or flag wrong");

  a_output_gate: assert property (
    $rose(st.core.oe) |-> st.out_line == st.otl ##1 !st.core.oe |-> !st.out_line)
    else $error("output line not gated by enable");

  // a software latch write leaves the following cycle free of reloads
  a_sw_no_reload: assert property (
    s_latch_write ##1 (!core_evt && !i_wr && !reload_hit[1] && st.aux[0].mode == gpt_pkg::MODE_RELOAD &&
                       st.aux[0].sel[2]) |=> $stable(st.core_cnt))
    else $error("latch write caused a reload");

  a_pwm_alternate: assert property (
    s_quiet_ovf and s_pwm_pair |=> st.core_cnt == ($past(st.otl) ? $past(st.aux_cnt[1]) : $past(st.aux_cnt[0])))
    else $error("alternate reload took the wrong timer");

  // capture ignores the top edge bit
  a_cap_top_ignored: assert property (
    st.aux[0].mode == gpt_pkg::MODE_CAPTURE && st.aux[0].sel[2] &&
    st.aux[0].sel[1:0] == gpt_pkg::EDGE_PIN_RISE[1:0] && pin_rise[1] && !i_wr |=> st.aux_cnt[0] == $past(st.core_cnt))
    else $error("capture with top edge bit set missed its edge");

  a_cap_flag_a: assert property (
    cap_hit[0] |=> st.irq[gpt_pkg::IRQ_AUXA])
    else $error("capture did not set flag");

  a_edge_disabled: assert property (
    st.aux[0].mode == gpt_pkg::MODE_COUNTER && st.aux[0].sel[1:0] == '0 && !i_wr |=> $stable(st.aux_cnt[0]))
    else $error("disabled edge code still counted");

  a_remote_stop: assert property (
    st.aux[0].remote && !st.core.run && st.aux[0].mode == gpt_pkg::MODE_COUNTER && !i_wr
      |=> $stable(st.aux_cnt[0]))
    else $error("remote run did not stop timer");

  // read data stand for one cycle only
  a_rdata_idle: assert property (
    !i_rd |=> st.rdata == '0)
    else $error("read data outside read cycle");

endmodule

// [rtl/gpt_pkg.sv]
/*
  Shared constants and types for the auxiliary timer chain block: register
  indices, control word layout, mode codes, edge codes and counter limits.
  Assumes a 100 MHz module clock and a 16-bit plain register port.
*/
package gpt_pkg;

  localparam int          DATA_W      = 16;
  localparam int          ADDR_W      = 3;
  localparam int          NUM_AUX     = 2;
  localparam int          NUM_PINS    = NUM_AUX + 1;

  // register indices on the plain port
  localparam logic [2:0]  REG_CORE_CON = 3'h0;
  localparam logic [2:0]  REG_CORE_CNT = 3'h1;
  localparam logic [2:0]  REG_AUXA_CON = 3'h2;
  localparam logic [2:0]  REG_AUXA_CNT = 3'h3;
  localparam logic [2:0]  REG_AUXB_CON = 3'h4;
  localparam logic [2:0]  REG_AUXB_CNT = 3'h5;
  localparam logic [2:0]  REG_IRQ      = 3'h6;

  // mode field codes
  localparam logic [2:0]  MODE_TIMER    = 3'h0;
  localparam logic [2:0]  MODE_COUNTER  = 3'h1;
  localparam logic [2:0]  MODE_GATED_HI = 3'h2;
  localparam logic [2:0]  MODE_GATED_LO = 3'h3;
  localparam logic [2:0]  MODE_RELOAD   = 3'h4;
  localparam logic [2:0]  MODE_CAPTURE  = 3'h5;

  // edge select codes
  localparam logic [2:0]  EDGE_PIN_RISE = 3'h1;
  localparam logic [2:0]  EDGE_PIN_FALL = 3'h2;
  localparam logic [2:0]  EDGE_PIN_ANY  = 3'h3;
  localparam logic [2:0]  EDGE_OTL_RISE = 3'h5;
  localparam logic [2:0]  EDGE_OTL_FALL = 3'h6;
  localparam logic [2:0]  EDGE_OTL_ANY  = 3'h7;

  // interrupt flag positions
  localparam int          IRQ_CORE = 0;
  localparam int          IRQ_AUXA = 1;
  localparam int          IRQ_AUXB = 2;
  localparam int          IRQ_W    = 3;

  // timer mode base rate is the module clock divided by eight
  localparam int          PSC_BASE = 8;
  localparam int          PSC_W    = 10;

  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;

  // control word, bit 0 upward: mode, edge select, run, down, remote, out enable
  typedef struct packed {
    logic       oe;
    logic       remote;
    logic       down;
    logic       run;
    logic [2:0] sel;
    logic [2:0] mode;
  } con_t;

  localparam int          CON_W   = $bits(con_t);
  localparam int          OTL_BIT = 8;

endpackage

// [rtl/edge_sampler.sv]
/*
  Two-flop synchroniser with edge detection for asynchronous input pins.
  Assumes each pin level holds for several clocks so that no edge is lost.
*/
`timescale 1ns/1ps
module edge_sampler #(
  parameter int N = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [N-1:0] i_pins,
  output logic      [N-1:0] o_level,
  output logic      [N-1:0] o_rise,
  output logic      [N-1:0] o_fall
);

  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] prev;
  } samp_t;

  samp_t st;
  samp_t next_st;

  always_comb begin
    next_st       = st;
    next_st.sync1 = i_pins;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.sync2;
  assign o_rise  = st.sync2 & ~st.prev;
  assign o_fall  = ~st.sync2 & st.prev;

endmodule

// [rtl/prescale_counter.sv]
/*
  Free-running prescaler count shared by all timers in timer and gated modes.
  Assumes the consumers derive one-cycle tick enables from the count.
*/
`timescale 1ns/1ps
module prescale_counter (
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  output logic      [gpt_pkg::PSC_W-1:0] o_count
);

  typedef struct packed {
    logic [gpt_pkg::PSC_W-1:0] count;
  } psc_t;

  psc_t st;
  psc_t next_st;

  always_comb begin
    next_st       = st;
    next_st.count = st.count + gpt_pkg::PSC_W'(1);
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_count = st.count;

endmodule

// [tb/ext_pin_model.sv]
/*
  Model of the outside party that drives the core, aux a and aux b pins.
  Assumes the bench calls its tasks from one process at a time.
*/
`timescale 1ns/1ps
module ext_pin_model (
  input  wire logic       i_clk,
  output logic      [2:0] o_pins
);
  localparam int HOLD = 8;

  initial o_pins = 3'h0;

  // every level stands HOLD clocks, well over the four the sampler needs
  task automatic drive(input int idx, input logic lvl);
    @(posedge i_clk);
    o_pins[idx] <= lvl;
    repeat (HOLD) @(posedge i_clk);
  endtask

  task automatic pulse(input int idx);
    drive(idx, 1'b1);
    drive(idx, 1'b0);
  endtask
endmodule

// [tb/aux_timer_chain_tb.sv]
/*
  Self-checking bench for the auxiliary timer chain: register rows, chaining,
  latch writes, alternate reload, capture, pin counting, remote run and reset.
  Assumes the pin model ext_pin_model and the package gpt_pkg.
*/
`timescale 1ns/1ps
module aux_timer_chain_tb;
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } row_t;

  logic        clk;
  logic        resetn;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        out_line;
  logic [2:0]  flags;
  logic [2:0]  pins;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles     = 0;
  row_t        rows [6];

  ext_pin_model pm (.i_clk(clk), .o_pins(pins));

  aux_timer_chain dut (
    .i_clk             (clk),
    .i_resetn          (resetn),
    .i_core_pin        (pins[0]),
    .i_aux_a_pin       (pins[1]),
    .i_aux_b_pin       (pins[2]),
    .i_addr            (addr),
    .i_wdata           (wdata),
    .i_wr              (wr),
    .i_rd              (rd),
    .o_rdata           (rdata),
    .o_core_output_line(out_line),
    .o_irq_flags       (flags)
  );

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      conclude();
    end
  end

  function automatic logic [15:0] mk(input logic [2:0] mode, input logic [2:0] sel, input logic run,
                                     input logic down, input logic b8, input logic oe);
    return {6'h00, oe, b8, down, run, sel, mode};
  endfunction

  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // read data stand only in the cycle after the read edge
  task automatic chkreg(input string name, input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic overflow_once;
    wreg(gpt_pkg::REG_CORE_CNT, gpt_pkg::CNT_MAX);
    pm.pulse(0);
  endtask

  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    clk    = 1'b0;
    resetn = 1'b0;
    addr   = 3'h0;
    wdata  = 16'h0000;
    wr     = 1'b0;
    rd     = 1'b0;
    rows[0] = '{gpt_pkg::REG_CORE_CNT, 16'h1234, 16'h1234};
    rows[1] = '{gpt_pkg::REG_AUXA_CNT, 16'hABCD, 16'hABCD};
    rows[2] = '{gpt_pkg::REG_AUXB_CNT, 16'h8001, 16'h8001};
    rows[3] = '{gpt_pkg::REG_AUXA_CON, 16'h02C5, 16'h00C5};
    rows[4] = '{gpt_pkg::REG_CORE_CON, 16'hFC80, 16'h0080};
    rows[5] = '{3'h7, 16'hFFFF, 16'h0000};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) chkreg("reset value", 3'(a), 16'h0000);
    foreach (rows[i]) begin
      wreg(rows[i].addr, rows[i].wdata);
      chkreg("register row", rows[i].addr, rows[i].exp);
    end
    // chaining: aux a on both latch edges, aux b on rising edge counting down
    wreg(gpt_pkg::REG_CORE_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_PIN_RISE, 1, 0, 0, 0));
    wreg(gpt_pkg::REG_AUXA_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_OTL_ANY, 1, 0, 0, 0));
    wreg(gpt_pkg::REG_AUXB_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_OTL_RISE, 1, 1, 0, 0));
    wreg(gpt_pkg::REG_AUXA_CNT, 16'h0000);
    wreg(gpt_pkg::REG_AUXB_CNT, 16'h0000);
    repeat (4) overflow_once();
    chkreg("aux a 32-bit", gpt_pkg::REG_AUXA_CNT, 16'h0004);
    chkreg("aux b 33-bit", gpt_pkg::REG_AUXB_CNT, 16'hFFFE);
    chkreg("core wrapped", gpt_pkg::REG_CORE_CNT, 16'h0000);
    chkreg("latch back", gpt_pkg::REG_CORE_CON, 16'h0049);
    settle();
    chk("read idle", 16'h0000, rdata);
    // software latch writes neither count nor drive the line without enable
    wreg(gpt_pkg::REG_CORE_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_PIN_RISE, 1, 0, 1, 0));
    settle();
    chk("line disabled", 16'h0000, {15'h0000, out_line});
    wreg(gpt_pkg::REG_CORE_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_PIN_RISE, 1, 0, 1, 1));
    settle();
    chk("line enabled", 16'h0001, {15'h0000, out_line});
    wreg(gpt_pkg::REG_CORE_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_PIN_RISE, 1, 0, 0, 1));
    chkreg("aux a no soft", gpt_pkg::REG_AUXA_CNT, 16'h0004);
    chkreg("aux b no soft", gpt_pkg::REG_AUXB_CNT, 16'hFFFE);
    // alternate reload for pwm
    wreg(gpt_pkg::REG_AUXA_CON, mk(gpt_pkg::MODE_RELOAD, gpt_pkg::EDGE_OTL_RISE, 1, 0, 0, 0));
    wreg(gpt_pkg::REG_AUXB_CON, mk(gpt_pkg::MODE_RELOAD, gpt_pkg::EDGE_OTL_FALL, 1, 0, 0, 0));
    wreg(gpt_pkg::REG_AUXA_CNT, 16'h0100);
    wreg(gpt_pkg::REG_AUXB_CNT, 16'h0200);
    wreg(gpt_pkg::REG_IRQ, 16'h0007);
    overflow_once();
    chkreg("reload high", gpt_pkg::REG_CORE_CNT, 16'h0100);
    chk("flags rise", 16'h0003, {13'h0000, flags});
    chk("line high", 16'h0001, {15'h0000, out_line});
    wreg(gpt_pkg::REG_IRQ, 16'h0007);
    overflow_once();
    chkreg("reload low", gpt_pkg::REG_CORE_CNT, 16'h0200);
    chk("flags fall", 16'h0005, {13'h0000, flags});
    chkreg("aux a stopped", gpt_pkg::REG_AUXA_CNT, 16'h0100);
    wreg(gpt_pkg::REG_CORE_CNT, 16'h0033);
    wreg(gpt_pkg::REG_CORE_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_PIN_RISE, 1, 0, 1, 1));
    chkreg("no soft reload", gpt_pkg::REG_CORE_CNT, 16'h0033);
    // both timers on the same trigger: the second one wins
    wreg(gpt_pkg::REG_AUXA_CON, mk(gpt_pkg::MODE_RELOAD, gpt_pkg::EDGE_OTL_ANY, 0, 0, 0, 0));
    wreg(gpt_pkg::REG_AUXB_CON, mk(gpt_pkg::MODE_RELOAD, gpt_pkg::EDGE_OTL_ANY, 0, 0, 0, 0));
    overflow_once();
    chkreg("same trigger", gpt_pkg::REG_CORE_CNT, 16'h0200);
    // capture with the top edge bit set on aux a
    wreg(gpt_pkg::REG_CORE_CON, 16'h0000);
    wreg(gpt_pkg::REG_IRQ, 16'h0007);
    wreg(gpt_pkg::REG_AUXA_CON, mk(gpt_pkg::MODE_CAPTURE, 3'h5, 0, 0, 0, 0));
    wreg(gpt_pkg::REG_AUXB_CON, mk(gpt_pkg::MODE_CAPTURE, gpt_pkg::EDGE_PIN_FALL, 0, 0, 0, 0));
    wreg(gpt_pkg::REG_CORE_CNT, 16'h1234);
    pm.drive(1, 1'b1);
    pm.drive(2, 1'b1);
    chkreg("capture a", gpt_pkg::REG_AUXA_CNT, 16'h1234);
    chk("flag a", 16'h0002, {13'h0000, flags});
    wreg(gpt_pkg::REG_CORE_CNT, 16'h5555);
    pm.drive(1, 1'b0);
    pm.drive(2, 1'b0);
    chkreg("no capture fall", gpt_pkg::REG_AUXA_CNT, 16'h1234);
    chkreg("capture b", gpt_pkg::REG_AUXB_CNT, 16'h5555);
    chk("flag b", 16'h0006, {13'h0000, flags});
    // core in gated mode with its pin low holds the chain, plain timer mode feeds it
    wreg(gpt_pkg::REG_AUXA_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_OTL_ANY, 1, 0, 0, 0));
    wreg(gpt_pkg::REG_AUXA_CNT, 16'h0000);
    wreg(gpt_pkg::REG_CORE_CNT, gpt_pkg::CNT_MAX);
    wreg(gpt_pkg::REG_CORE_CON, mk(gpt_pkg::MODE_GATED_HI, 3'h0, 1, 0, 0, 0));
    repeat (24) @(posedge clk);
    chkreg("gated low", gpt_pkg::REG_AUXA_CNT, 16'h0000);
    wreg(gpt_pkg::REG_CORE_CON, mk(gpt_pkg::MODE_TIMER, 3'h0, 1, 0, 0, 0));
    repeat (24) @(posedge clk);
    chkreg("timer chain", gpt_pkg::REG_AUXA_CNT, 16'h0001);
    // own pin counting, disabled code, then remote run
    wreg(gpt_pkg::REG_AUXA_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_PIN_ANY, 1, 0, 0, 0));
    wreg(gpt_pkg::REG_AUXA_CNT, 16'h0000);
    pm.pulse(1);
    chkreg("pin any", gpt_pkg::REG_AUXA_CNT, 16'h0002);
    wreg(gpt_pkg::REG_AUXA_CON, mk(gpt_pkg::MODE_COUNTER, 3'h4, 1, 0, 0, 0));
    pm.pulse(1);
    chkreg("disabled", gpt_pkg::REG_AUXA_CNT, 16'h0002);
    wreg(gpt_pkg::REG_AUXA_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_PIN_RISE, 0, 0, 1, 0));
    wreg(gpt_pkg::REG_CORE_CON, mk(gpt_pkg::MODE_COUNTER, gpt_pkg::EDGE_PIN_RISE, 1, 0, 0, 0));
    pm.pulse(1);
    chkreg("remote on", gpt_pkg::REG_AUXA_CNT, 16'h0003);
    wreg(gpt_pkg::REG_CORE_CON, 16'h0000);
    pm.pulse(1);
    chkreg("remote off", gpt_pkg::REG_AUXA_CNT, 16'h0003);
    // reset in mid-run clears state and sticky flags
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("flags reset", 16'h0000, {13'h0000, flags});
    chkreg("count reset", gpt_pkg::REG_AUXA_CNT, 16'h0000);
    conclude();
  end
endmodule
